// ==== src/socs_outen_clksel.sv ====
`timescale 1ns/1ps
// Operation
// - Eleven-bit shift register plus separate control register
// - Mode high: strobe shifts data into stage zero
// - Eleven shifts fill, twelfth strobe commits word
// - Bit 0 drives pair nine, bit 9 pair zero
// - Control bit 10 picks alternate clock input
// - Zero enable bit tristates that output pair
// - Strobe with mode low resets everything
// - Only one commit accepted after each reset
// - Mode low: all pairs enabled, control ignored
// - Mode low, data high: alternate clock
// - Mode low, data low: primary clock default
// - Enabled pair delivers clock within 1 us
// - Strobe up to 100 MHz; shift logic samples it on the 25 ns clk, so each level must last over one period
module socs_outen_clksel import socs_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic config_shift_strobe,
    input wire logic serial_data_in,
    input wire logic mode_pin,
    input wire logic primary_clock_in,
    input wire logic alternate_clock_in,
    output logic [9:0] fanout_output_pair,
    output logic [9:0] fanout_output_pair_oe,
    output logic alternate_selected
);
    typedef struct packed {
        logic [2:0] strobe_sync;
        logic [1:0] data_sync;
        logic [1:0] mode_sync;
        logic [10:0] shift_reg;
        logic [10:0] ctrl_reg;
        logic [3:0] count_reg;
        socs_phase_e phase_reg;
        logic [9:0] oe_reg;
        logic sel_reg;
    } socs_state_s;

    socs_state_s state_reg;
    socs_state_s state_next;
    logic strobe_rise;
    logic data_s;
    logic mode_s;
    logic src_clock;

    // Synchronised pins; edge found on second and third stages
    assign data_s = state_reg.data_sync[1];
    assign mode_s = state_reg.mode_sync[1];
    assign strobe_rise = state_reg.strobe_sync[1] &
        ~state_reg.strobe_sync[2];

    // Next-state logic for shift, commit and reset
    always_comb begin
        state_next = state_reg;
        state_next.strobe_sync = {state_reg.strobe_sync[1:0],
            config_shift_strobe};
        state_next.data_sync = {state_reg.data_sync[0], serial_data_in};
        state_next.mode_sync = {state_reg.mode_sync[0], mode_pin};
        if (strobe_rise) begin
            if (!mode_s) begin
                // Reset of machine, shift and control registers
                state_next.shift_reg = SOCS_SHIFT_RESET;
                state_next.ctrl_reg = SOCS_CTRL_RESET;
                state_next.count_reg = SOCS_COUNT_RESET;
                state_next.phase_reg = SOCS_FILL;
            end else if (state_reg.phase_reg == SOCS_FILL) begin
                if (state_reg.count_reg < SOCS_FILL_COUNT) begin
                    // New bit enters stage zero, others move up
                    state_next.shift_reg = {state_reg.shift_reg[9:0],
                        data_s};
                    state_next.count_reg = state_reg.count_reg + 4'h1;
                end else begin
                    state_next.ctrl_reg = state_reg.shift_reg;
                    state_next.phase_reg = SOCS_LOCKED;
                end
            end
            // Locked phase: further strobes leave control alone
        end
        // Output enables and source choice
        if (!mode_s) begin
            state_next.oe_reg = {SOCS_PAIRS{1'b1}};
            state_next.sel_reg = data_s;
        end else begin
            // First shifted bit ends in stage 10 after eleven shifts;
            // stage 10 is bit 0 -> pair 9, stage 1 is bit 9 -> pair 0
            for (int i = 0; i < SOCS_PAIRS; i++) begin
                state_next.oe_reg[i] = state_reg.ctrl_reg[i + 1];
            end
            state_next.sel_reg = state_reg.ctrl_reg[0];
        end
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '{strobe_sync: 3'h0, data_sync: 2'h0,
                mode_sync: 2'h0, shift_reg: SOCS_SHIFT_RESET,
                ctrl_reg: SOCS_CTRL_RESET, count_reg: SOCS_COUNT_RESET,
                phase_reg: SOCS_FILL, oe_reg: 10'h3FF, sel_reg: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // Clock path is combinational fanout of the chosen source
    assign src_clock = state_reg.sel_reg ? alternate_clock_in
        : primary_clock_in;
    assign fanout_output_pair = {SOCS_PAIRS{src_clock}} &
        state_reg.oe_reg;
    assign fanout_output_pair_oe = state_reg.oe_reg;
    assign alternate_selected = state_reg.sel_reg;

    // Checks
    sequence s_reset_strobe;
        strobe_rise && !mode_s;
    endsequence

    sequence s_commit;
        strobe_rise && mode_s && state_reg.phase_reg == SOCS_FILL &&
            state_reg.count_reg == SOCS_FILL_COUNT;
    endsequence

    a_reset_clears: assert property (@(posedge clk) disable iff (!reset_n)
        s_reset_strobe |=> state_reg.count_reg == 4'h0 &&
            state_reg.phase_reg == SOCS_FILL)
        else $error("reset strobe did not clear machine");

    a_shift_in: assert property (@(posedge clk) disable iff (!reset_n)
        strobe_rise && mode_s && state_reg.phase_reg == SOCS_FILL &&
        state_reg.count_reg < SOCS_FILL_COUNT |=>
        state_reg.shift_reg[0] == $past(data_s))
        else $error("shift stage zero wrong");

    a_commit_load: assert property (@(posedge clk) disable iff (!reset_n)
        s_commit |=> state_reg.ctrl_reg == $past(state_reg.shift_reg) &&
            state_reg.phase_reg == SOCS_LOCKED)
        else $error("commit did not load control");

    a_locked_hold: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg.phase_reg == SOCS_LOCKED && mode_s |=>
        $stable(state_reg.ctrl_reg))
        else $error("control changed while locked");

    a_standard_all: assert property (@(posedge clk) disable iff (!reset_n)
        !mode_s |=> fanout_output_pair_oe == 10'h3FF)
        else $error("standard mode not all enabled");

    a_standard_sel: assert property (@(posedge clk) disable iff (!reset_n)
        !mode_s ##1 !mode_s |-> alternate_selected == $past(data_s))
        else $error("standard mode source wrong");

    a_prog_map: assert property (@(posedge clk) disable iff (!reset_n)
        mode_s |=> fanout_output_pair_oe[9] == $past(state_reg.ctrl_reg[10])
            && alternate_selected == $past(state_reg.ctrl_reg[0]))
        else $error("programmed mapping wrong");

    a_startup_time: assert property (@(posedge clk) disable iff (!reset_n)
        s_commit ##1 mode_s |=> fanout_output_pair_oe ==
            $past(state_reg.ctrl_reg[10:1]))
        else $error("enable not applied in time");

    a_disabled_low: assert property (@(posedge clk) disable iff (!reset_n)
        fanout_output_pair_oe[0] == 1'b0 |-> !fanout_output_pair[0])
        else $error("disabled pair driving");

    // One shift step while filling
    sequence s_shift_step;
        strobe_rise && mode_s && state_reg.phase_reg == SOCS_FILL &&
            state_reg.count_reg < SOCS_FILL_COUNT;
    endsequence

    // Strobe seen while the word is already locked
    sequence s_locked_strobe;
        strobe_rise && mode_s && state_reg.phase_reg == SOCS_LOCKED;
    endsequence

    // Older stages move up by one place on each shift
    a_shift_move: assert property (@(posedge clk) disable iff (!reset_n)
        s_shift_step |=>
        state_reg.shift_reg[10:1] == $past(state_reg.shift_reg[9:0]))
        else $error("shift stages did not move up");

    // Bit counter steps by one per shift
    a_count_step: assert property (@(posedge clk) disable iff (!reset_n)
        s_shift_step |=>
        state_reg.count_reg == $past(state_reg.count_reg) + 4'h1)
        else $error("bit counter did not step");

    // Counter never runs past the fill count
    a_count_bound: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg.count_reg <= SOCS_FILL_COUNT)
        else $error("bit counter overran");

    // Shifting alone leaves the control word alone
    a_fill_hold: assert property (@(posedge clk) disable iff (!reset_n)
        s_shift_step |=> $stable(state_reg.ctrl_reg))
        else $error("control changed while filling");

    // Reset strobe clears the shift stages
    a_reset_shift: assert property (@(posedge clk) disable iff (!reset_n)
        s_reset_strobe |=> state_reg.shift_reg == SOCS_SHIFT_RESET)
        else $error("reset strobe left shift data");

    // Reset strobe restores the control word
    a_reset_ctrl: assert property (@(posedge clk) disable iff (!reset_n)
        s_reset_strobe |=> state_reg.ctrl_reg == SOCS_CTRL_RESET)
        else $error("reset strobe left control word");

    // Further strobes neither move the phase nor the shift stages
    a_locked_phase: assert property (@(posedge clk) disable iff (!reset_n)
        s_locked_strobe |=> state_reg.phase_reg == SOCS_LOCKED &&
            $stable(state_reg.shift_reg))
        else $error("locked phase left on strobe");

    // Programmed source choice follows control stage 0
    a_prog_sel: assert property (@(posedge clk) disable iff (!reset_n)
        mode_s |=> alternate_selected == $past(state_reg.ctrl_reg[0]))
        else $error("programmed source wrong");

    // Lowest pair follows the last enable bit shifted
    a_prog_low: assert property (@(posedge clk) disable iff (!reset_n)
        mode_s |=>
        fanout_output_pair_oe[0] == $past(state_reg.ctrl_reg[1]))
        else $error("pair zero mapping wrong");

    // Mode low with data low picks the primary source
    a_standard_pri: assert property (@(posedge clk) disable iff (!reset_n)
        !mode_s && !data_s |=> !alternate_selected)
        else $error("default source not primary");

    // Source clock follows the selected input clock
    a_source_path: assert property (@(posedge clk) disable iff (!reset_n)
        src_clock == (alternate_selected ? alternate_clock_in
            : primary_clock_in))
        else $error("source clock path wrong");

    // Each pair carries the source clock only while enabled
    for (genvar p = 0; p < SOCS_PAIRS; p++) begin : g_pair_chk
        a_pair_gate: assert property (@(posedge clk)
            disable iff (!reset_n)
            fanout_output_pair[p] ==
                (src_clock & fanout_output_pair_oe[p]))
            else $error("pair gating wrong");
    end
endmodule : socs_outen_clksel

// ==== common/socs_pkg.sv ====
package socs_pkg;
    // Shift and control word width, fanout pairs
    localparam int SOCS_WORD_W = 11;
    localparam int SOCS_PAIRS = 10;
    localparam int SOCS_SEL_BIT = 10;
    // Shift pulses before the commit pulse
    localparam logic [3:0] SOCS_FILL_COUNT = 4'hB;
    // Control word after reset: all pairs on, primary clock
    // Stage 0 holds the source bit, stages 10..1 the pair enables
    localparam logic [10:0] SOCS_CTRL_RESET = 11'h7FE;
    localparam logic [10:0] SOCS_SHIFT_RESET = 11'h000;
    localparam logic [3:0] SOCS_COUNT_RESET = 4'h0;
    // Startup time after enable, and system clock period
    localparam int SOCS_STARTUP_NS = 1000;
    localparam int SOCS_CLK_PERIOD_NS = 25;
    localparam int SOCS_STARTUP_CYC = SOCS_STARTUP_NS / SOCS_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SOCS_FILL,
        SOCS_LOCKED
    } socs_phase_e;
endpackage : socs_pkg

// ==== tb/socs_ctrl_model.sv ====
`timescale 1ns/1ps
// Controller on the serial configuration pins
module socs_ctrl_model (
    input wire logic clk,
    output logic config_shift_strobe,
    output logic serial_data_in,
    output logic mode_pin
);
    initial begin
        config_shift_strobe = 1'b0;
        serial_data_in = 1'b0;
        mode_pin = 1'b0;
    end
    // Set mode and data levels without a strobe
    task automatic hold(input logic m, input logic d);
        mode_pin <= m;
        serial_data_in <= d;
    endtask : hold
    // One 100 ns strobe, pins held around the rising edge
    task automatic pulse(input logic m, input logic d);
        hold(m, d);
        repeat (4) @(posedge clk);
        config_shift_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        config_shift_strobe <= 1'b0;
    endtask : pulse
    // Reset strobe, then n strobes carrying bit 0 upward
    task automatic send(input logic [10:0] w, input int n);
        pulse(1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            pulse(1'b1, (i < 11) ? w[i] : ~w[0]);
        end
    endtask : send
endmodule : socs_ctrl_model

// ==== tb/serial_outen_clksel_test.sv ====
`timescale 1ns/1ps
module serial_outen_clksel_test;
    import socs_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic pri_in = 1'b0;
    logic alt_in = 1'b0;
    logic strobe, sdata, mode, sel;
    logic [9:0] q, oe;
    logic [10:0] w;
    int error_cnt = 0;
    int checked = 0;
    int seed = 32'hbbda;
    int cyc = 0;
    // Clock and random source clocks
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        pri_in <= 1'($random(seed));
        alt_in <= 1'($random(seed));
    end
    socs_ctrl_model i_ctl (.clk(clk), .config_shift_strobe(strobe),
        .serial_data_in(sdata), .mode_pin(mode));
    socs_outen_clksel i_dut (.clk(clk), .reset_n(reset_n),
        .config_shift_strobe(strobe), .serial_data_in(sdata),
        .mode_pin(mode), .primary_clock_in(pri_in),
        .alternate_clock_in(alt_in), .fanout_output_pair(q),
        .fanout_output_pair_oe(oe), .alternate_selected(sel));
    task automatic conclude();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    // Compare enables, source and gated clocks with the model word
    task automatic chk(input int c, input logic m, input logic d);
        logic [10:0] e;
        logic [9:0] eq;
        @(negedge clk);
        for (int i = 0; i < 10; i++) begin
            e[9 - i] = m ? c[i] : 1'b1;
        end
        e[10] = m ? c[10] : d;
        eq = e[9:0] & {10{e[10] ? alt_in : pri_in}};
        checked++;
        if ({oe, sel, q} !== {e[9:0], e[10], eq}) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, {oe, sel, q},
                {e[9:0], e[10], eq});
        end
    endtask : chk
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        for (int t = 0; t < 6; t++) begin
            w = 11'($random(seed));
            i_ctl.send(w, (t == 5) ? 11 : 12);
            repeat (8) @(posedge clk);
            chk((t == 5) ? 'h3FF : int'(w), 1'b1, 1'b0);
            i_ctl.pulse(1'b1, ~w[1]);
            i_ctl.pulse(1'b1, w[2]);
            repeat (8) @(posedge clk);
            chk(int'(w), 1'b1, 1'b0);
            $display("test %0d done", t);
        end
        for (int d = 0; d < 2; d++) begin
            i_ctl.hold(1'b0, d[0]);
            repeat (6) @(posedge clk);
            chk(0, 1'b0, d[0]);
        end
        $display("test mode low done");
        conclude();
    end
endmodule : serial_outen_clksel_test
